// File: src/sync_serial_receiver.sv
// synchronous serial receiver, clock master or slave, with ahb-lite register port
//
// Notes on behaviour
// [R1] slave takes link clock, clock driver off
// [R2] data changes leading edge, sampled trailing
// [R3] one data bit shifted per link clock
// [R4] master gives only data-bit count clocks
// [R5] fifo holds two; third char overruns
// [R6] overrun sets flag, new char discarded
// [R7] stored chars readable, reception halted meanwhile
// [R8] overrun flag cleared only by actions
// [R9] single-receive overrun cleared by data read
// [R10] continuous overrun cleared by continuous_receive_enable/enable clear
// [R11] nine bits shifted; ninth bit from head
// [R12] read ninth bit before data word
// [R13] baud from 16-bit divisor, speed selects
// [R14] software sets master mode, receive bits clear
// [R15] master receive starts on single/continuous set
// [R16] receive flag on char; irq if enabled
// [R17] master drives clock, polarity sets idle
// [R18] single receive self-clears, clock then stops
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_regs.svh"

module sync_serial_receiver
	import sync_rx_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	sync_link_if.device      link,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic             hreadyout_o,
	output logic             hresp_o,
	output logic [31:0]      hrdata_o,
	output logic             irq_o
);
	dev_state_s          r;
	dev_state_s          next_r;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [`CHAR_W-1:0]  fifo_out_data;
	logic                fifo_pop;

	// half link period in system cycles less one; as master it must cover the far end's
	// two-flop sync and reply, so half periods under six cycles sample a stale bit
	function automatic logic [17:0] baud_reload(input logic [15:0] div, input logic wide,
		input logic fast);
		logic [15:0] base;
		base = wide ? div : {8'h00, div[7:0]};
		baud_reload = fast ? {2'b00, base} : {base, 2'b11};
	endfunction

	// ***************************************
	// receive fifo
	// ***************************************
	assign fifo_pop = r.bus_pend && !r.bus_wr && (r.bus_addr == `OFS_DATA);

	char_fifo #(
		.WIDTH (`CHAR_W),
		.DEPTH (`RX_FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.sys_rst_i   (sys_rst_i),
		.flush_i     (!r.serial_port_enable),
		.in_valid_i  (r.push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (r.push_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out_data)
	);

	// ***************************************
	// next state
	// ***************************************
	always_comb begin
		logic              go;
		logic              lead;
		logic              trail;
		logic [3:0]        last;
		logic [17:0]       reload;
		logic [`CHAR_W-1:0] sh;
		go     = 1'b0;
		lead   = 1'b0;
		trail  = 1'b0;
		last   = '0;
		reload = '0;
		sh     = '0;
		next_r = r;
		next_r.push    = 1'b0;
		next_r.ck_sync = {r.ck_sync[0], link.transmit_clock_pin};
		next_r.dt_sync = {r.dt_sync[0], link.receive_data_pin};
		next_r.ck_prev = r.ck_sync[1];

		// bus address phase, one wait state before each answer
		if (hsel_i && htrans_i[1] && hready_i && !r.bus_pend) begin
			next_r.bus_pend  = 1'b1;
			next_r.bus_wr    = hwrite_i;
			next_r.bus_addr  = haddr_i[7:0];
			next_r.hreadyout = 1'b0;
		end
		// bus data phase
		if (r.bus_pend) begin
			next_r.bus_pend  = 1'b0;
			next_r.hreadyout = 1'b1;
			next_r.hrdata    = '0;
			if (r.bus_wr) begin
				case (r.bus_addr)
					`OFS_CONTROL: begin
						next_r.serial_port_enable        = hwdata_i[`BIT_SERIAL_PORT_ENABLE];
						next_r.clock_source_master       = hwdata_i[`BIT_CLOCK_SOURCE_MASTER];
						next_r.single_receive_enable     = hwdata_i[`BIT_SINGLE_RECEIVE_ENABLE];
						next_r.continuous_receive_enable = hwdata_i[`BIT_CONTINUOUS_RECEIVE];
						next_r.ninth_bit_receive_enable  = hwdata_i[`BIT_NINTH_BIT_RECEIVE];
						next_r.high_speed_baud_select    = hwdata_i[`BIT_HIGH_SPEED_BAUD];
						next_r.wide_baud_counter_select  = hwdata_i[`BIT_WIDE_BAUD_COUNTER];
						next_r.clock_polarity_select     = hwdata_i[`BIT_CLOCK_POLARITY];
						next_r.receive_interrupt_enable  = hwdata_i[`BIT_RECEIVE_INT_ENABLE];
						if (r.overrun_in_continuous && !hwdata_i[`BIT_CONTINUOUS_RECEIVE]) begin
							next_r.overrun_error_flag = 1'b0; // R10
						end
					end
					`OFS_BAUD: begin
						next_r.baud_divisor = hwdata_i[15:0]; // R13
					end
					default: begin
					end
				endcase
			end else begin
				case (r.bus_addr)
					`OFS_CONTROL: begin
						next_r.hrdata[`BIT_SERIAL_PORT_ENABLE]    = r.serial_port_enable;
						next_r.hrdata[`BIT_CLOCK_SOURCE_MASTER]   = r.clock_source_master;
						next_r.hrdata[`BIT_SINGLE_RECEIVE_ENABLE] = r.single_receive_enable;
						next_r.hrdata[`BIT_CONTINUOUS_RECEIVE]    = r.continuous_receive_enable;
						next_r.hrdata[`BIT_NINTH_BIT_RECEIVE]     = r.ninth_bit_receive_enable;
						next_r.hrdata[`BIT_HIGH_SPEED_BAUD]       = r.high_speed_baud_select;
						next_r.hrdata[`BIT_WIDE_BAUD_COUNTER]     = r.wide_baud_counter_select;
						next_r.hrdata[`BIT_CLOCK_POLARITY]        = r.clock_polarity_select;
						next_r.hrdata[`BIT_RECEIVE_INT_ENABLE]    = r.receive_interrupt_enable;
					end
					`OFS_STATUS: begin
						next_r.hrdata[`BIT_RECEIVED_NINTH_BIT] = fifo_out_valid
							&& fifo_out_data[`CHAR_W-1]; // R11
						next_r.hrdata[`BIT_OVERRUN_ERROR_FLAG]     = r.overrun_error_flag;
						next_r.hrdata[`BIT_RECEIVE_INTERRUPT_FLAG] = fifo_out_valid; // R16
					end
					`OFS_DATA: begin
						next_r.hrdata[7:0] = fifo_out_valid ? fifo_out_data[7:0] : 8'h00;
						if (r.overrun_error_flag && !r.overrun_in_continuous) begin
							next_r.overrun_error_flag = 1'b0; // R9
						end
					end
					`OFS_BAUD: begin
						next_r.hrdata[15:0] = r.baud_divisor;
					end
					default: begin
					end
				endcase
			end
		end

		// receive engine
		go     = r.serial_port_enable && !r.overrun_error_flag
			&& (r.single_receive_enable || r.continuous_receive_enable); // R7 R15
		last   = r.ninth_bit_receive_enable ? `LAST_BIT_9 : `LAST_BIT_8; // R11
		reload = baud_reload(r.baud_divisor, r.wide_baud_counter_select,
			r.high_speed_baud_select); // R13
		case (r.st)
			RX_IDLE: begin
				next_r.ck = r.clock_polarity_select; // R17
				if (go) begin
					next_r.st       = RX_SHIFT;
					next_r.bit_idx  = '0;
					next_r.baud_cnt = reload;
				end
			end
			RX_SHIFT: begin
				if (r.clock_source_master) begin
					if (r.baud_cnt == '0) begin
						next_r.baud_cnt = reload;
						next_r.ck       = ~r.ck; // R17
						lead            = (r.ck == r.clock_polarity_select);
						trail           = !lead;
					end else begin
						next_r.baud_cnt = r.baud_cnt - 18'h00001;
					end
				end else begin
					trail = (r.ck_sync[1] == r.clock_polarity_select)
						&& (r.ck_prev != r.clock_polarity_select); // R1 R2
				end
				if (!(r.single_receive_enable || r.continuous_receive_enable)) begin
					next_r.st = RX_IDLE;
					next_r.ck = r.clock_polarity_select;
				end else if (trail) begin
					sh                          = r.receive_shift_register;
					sh[r.bit_idx]               = r.dt_sync[1]; // R2 R3
					next_r.receive_shift_register = sh;
					next_r.bit_idx              = r.bit_idx + 4'h1;
					if (r.bit_idx == last) begin
						next_r.st = RX_IDLE;
						if (fifo_in_ready) begin
							next_r.push      = 1'b1; // R5 R16
							next_r.push_data = {r.ninth_bit_receive_enable && sh[`CHAR_W-1],
								sh[7:0]};
						end else begin
							next_r.overrun_error_flag    = 1'b1; // R5 R6
							next_r.overrun_in_continuous = r.continuous_receive_enable;
						end
						if (r.clock_source_master && !r.continuous_receive_enable) begin
							next_r.single_receive_enable = 1'b0; // R18
						end
					end
				end
			end
			default: begin
				next_r.st = RX_IDLE;
			end
		endcase

		// disabling the port resets the whole receive unit
		if (!r.serial_port_enable) begin
			next_r.st                 = RX_IDLE;
			next_r.overrun_error_flag = 1'b0; // R8 R10
			next_r.bit_idx            = '0;
			next_r.ck                 = r.clock_polarity_select;
		end
		next_r.ck_oe_n = !(r.serial_port_enable && r.clock_source_master); // R1 R17
		next_r.irq     = fifo_out_valid && r.receive_interrupt_enable; // R16
	end

	// ***************************************
	// state register
	// ***************************************
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			r              <= '0;
			r.st           <= RX_IDLE;
			r.baud_divisor <= `BAUD_RESET_VAL;
			r.ck_oe_n      <= 1'b1;
			r.hreadyout    <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign link.dev_ck      = r.ck;
	assign link.dev_ck_oe_n = r.ck_oe_n;
	assign hreadyout_o      = r.hreadyout;
	assign hresp_o          = 1'b0; // always okay
	assign hrdata_o         = r.hrdata;
	assign irq_o            = r.irq;
endmodule

`default_nettype wire

// File: src/sync_rx_regs.svh
// register offsets, field positions, reset values and timing counts of the serial link
`ifndef SYNC_RX_REGS_SVH
`define SYNC_RX_REGS_SVH

// ***************************************
// register byte offsets
// ***************************************
`define OFS_CONTROL          8'h00
`define OFS_STATUS           8'h04
`define OFS_DATA             8'h08
`define OFS_BAUD             8'h0c

// ***************************************
// control word field positions
// ***************************************
`define BIT_SERIAL_PORT_ENABLE       0
`define BIT_CLOCK_SOURCE_MASTER      1
`define BIT_SINGLE_RECEIVE_ENABLE    2
`define BIT_CONTINUOUS_RECEIVE       3
`define BIT_NINTH_BIT_RECEIVE        4
`define BIT_HIGH_SPEED_BAUD          5
`define BIT_WIDE_BAUD_COUNTER        6
`define BIT_CLOCK_POLARITY           7
`define BIT_RECEIVE_INT_ENABLE       8

// ***************************************
// status word field positions
// ***************************************
`define BIT_RECEIVED_NINTH_BIT       0
`define BIT_OVERRUN_ERROR_FLAG       1
`define BIT_RECEIVE_INTERRUPT_FLAG   2

// ***************************************
// reset values, sizes and timing
// ***************************************
`define BAUD_RESET_VAL       16'h0000
`define CHAR_W               9
`define RX_FIFO_DEPTH        2
`define LAST_BIT_8           4'h7
`define LAST_BIT_9           4'h8
`define SYS_PERIOD_NS        10
`define LINK_PERIOD_NS       125
`define PEER_HALF_CYC        ((`LINK_PERIOD_NS) / (2 * `SYS_PERIOD_NS))

`endif

// File: src/sync_rx_pkg.sv
// types shared by both ends of the synchronous serial link
`include "sync_rx_regs.svh"

package sync_rx_pkg;

	// ***************************************
	// receiver types
	// ***************************************
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b01,
		RX_SHIFT = 2'b10
	} rx_state_e;

	typedef struct packed {
		rx_state_e             st;
		logic                  serial_port_enable;
		logic                  clock_source_master;
		logic                  single_receive_enable;
		logic                  continuous_receive_enable;
		logic                  ninth_bit_receive_enable;
		logic                  high_speed_baud_select;
		logic                  wide_baud_counter_select;
		logic                  clock_polarity_select;
		logic                  receive_interrupt_enable;
		logic [15:0]           baud_divisor;
		logic                  overrun_error_flag;
		logic                  overrun_in_continuous;
		logic [`CHAR_W-1:0]    receive_shift_register;
		logic [3:0]            bit_idx;
		logic [17:0]           baud_cnt;
		logic                  ck;
		logic                  ck_oe_n;
		logic [1:0]            ck_sync;
		logic [1:0]            dt_sync;
		logic                  ck_prev;
		logic                  push;
		logic [`CHAR_W-1:0]    push_data;
		logic                  irq;
		logic                  bus_pend;
		logic                  bus_wr;
		logic [7:0]            bus_addr;
		logic                  hreadyout;
		logic [31:0]           hrdata;
	} dev_state_s;

	// ***************************************
	// peer types
	// ***************************************
	typedef enum logic [1:0] {
		PEER_IDLE = 2'b01,
		PEER_SEND = 2'b10
	} peer_state_e;

	typedef struct packed {
		peer_state_e           st;
		logic [`CHAR_W-1:0]    shreg;
		logic [3:0]            left;
		logic                  gen_ck;
		logic [7:0]            half_cnt;
		logic [1:0]            ck_sync;
		logic                  ck_prev;
		logic                  dt;
		logic                  dt_oe_n;
		logic                  ck_oe_n;
		logic                  ready;
	} peer_state_s;

endpackage

// File: src/sync_link_if.sv
// two-wire link between the receiver and its serial peer
`timescale 1ns/1ps
`default_nettype none

interface sync_link_if;
	logic dev_ck;
	logic dev_ck_oe_n;
	logic peer_ck;
	logic peer_ck_oe_n;
	logic peer_dt;
	logic peer_dt_oe_n;
	logic transmit_clock_pin;
	logic receive_data_pin;

	// wire levels from the enables, pulled high when nobody drives
	assign transmit_clock_pin = !dev_ck_oe_n ? dev_ck : (!peer_ck_oe_n ? peer_ck : 1'b1);
	assign receive_data_pin   = !peer_dt_oe_n ? peer_dt : 1'b1;

	modport device (output dev_ck, dev_ck_oe_n, input transmit_clock_pin, receive_data_pin);
	modport peer (output peer_ck, peer_ck_oe_n, peer_dt, peer_dt_oe_n, input transmit_clock_pin);
endinterface

`default_nettype wire

// File: src/char_fifo.sv
// small flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module char_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} fifo_state_s;

	fifo_state_s r;
	fifo_state_s next_r;
	logic        push;
	logic        pop;

	// pointer step with wrap at depth
	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready_o  = (r.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (r.cnt != '0);
	assign out_data_o  = r.mem[r.rd];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// next state of storage and pointers
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wr] = in_data_i;
			next_r.wr        = step(r.wr);
		end
		if (pop) begin
			next_r.rd = step(r.rd);
		end
		next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush_i) begin
			next_r.wr  = '0;
			next_r.rd  = '0;
			next_r.cnt = '0;
		end
	end

	// state register
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

`default_nettype wire

// File: src/sync_serial_peer.sv
// synchronous serial peer that sends characters, as clock master or clock slave
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_regs.svh"

module sync_serial_peer
	import sync_rx_pkg::*;
(
	input  wire logic               sys_clk_i,
	input  wire logic               sys_rst_i,
	sync_link_if.peer               link,
	input  wire logic               master_i,
	input  wire logic               polarity_i,
	input  wire logic               ninth_i,
	input  wire logic [`CHAR_W-1:0] tx_data_i,
	input  wire logic               tx_valid_i,
	output logic                    tx_ready_o
);
	peer_state_s r;
	peer_state_s next_r;

	// ***************************************
	// next state
	// ***************************************
	always_comb begin
		logic ck_now;
		logic lead;
		logic trail;
		ck_now = master_i ? r.gen_ck : r.ck_sync[1];
		lead   = (ck_now != polarity_i) && (r.ck_prev == polarity_i);
		trail  = (ck_now == polarity_i) && (r.ck_prev != polarity_i);
		next_r = r;
		next_r.ck_sync = {r.ck_sync[0], link.transmit_clock_pin};
		next_r.ck_prev = ck_now;
		next_r.ck_oe_n = !master_i;
		case (r.st)
			PEER_IDLE: begin
				next_r.gen_ck  = polarity_i;
				next_r.dt_oe_n = 1'b1;
				next_r.ready   = 1'b1;
				if (tx_valid_i && r.ready) begin
					next_r.st       = PEER_SEND;
					next_r.shreg    = tx_data_i;
					next_r.left     = ninth_i ? 4'h9 : 4'h8;
					next_r.ready    = 1'b0;
					next_r.dt_oe_n  = 1'b0;
					next_r.half_cnt = 8'(`PEER_HALF_CYC - 1);
				end
			end
			PEER_SEND: begin
				if (master_i) begin
					if (r.half_cnt == '0) begin
						next_r.half_cnt = 8'(`PEER_HALF_CYC - 1);
						next_r.gen_ck   = ~r.gen_ck; // R4
					end else begin
						next_r.half_cnt = r.half_cnt - 8'h01;
					end
				end
				if (lead) begin
					next_r.dt    = r.shreg[0]; // R2
					next_r.shreg = {1'b0, r.shreg[`CHAR_W-1:1]};
				end
				if (trail) begin
					next_r.left = r.left - 4'h1;
					if (r.left == 4'h1) begin
						next_r.st      = PEER_IDLE; // R4
						next_r.gen_ck  = polarity_i;
						next_r.dt_oe_n = 1'b1;
						next_r.ready   = 1'b1;
					end
				end
			end
			default: begin
				next_r.st = PEER_IDLE;
			end
		endcase
	end

	// ***************************************
	// state register
	// ***************************************
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			r         <= '0;
			r.st      <= PEER_IDLE;
			r.dt      <= 1'b1;
			r.dt_oe_n <= 1'b1;
			r.ck_oe_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign link.peer_ck      = r.gen_ck;
	assign link.peer_ck_oe_n = r.ck_oe_n;
	assign link.peer_dt      = r.dt;
	assign link.peer_dt_oe_n = r.dt_oe_n;
	assign tx_ready_o        = r.ready;
endmodule

`default_nettype wire

// File: bench/sync_link_checker.sv
// concurrent checks on the wires between receiver and peer
`timescale 1ns/1ps
`default_nettype none

module sync_link_checker (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic dev_ck_oe_n,
	input wire logic peer_ck_oe_n,
	input wire logic peer_dt_oe_n,
	input wire logic transmit_clock_pin,
	input wire logic receive_data_pin
);
	// ****************
	// helper state
	// ****************
	logic       ck_q;     // clock pin one cycle back
	logic       idle_lvl; // clock level between frames
	logic [3:0] hold_cnt; // stable clock cycles, saturating
	logic [3:0] n_trail;  // trailing edges in the running frame
	logic       trail;

	// trailing edge: clock returns to idle while data is driven
	assign trail = (transmit_clock_pin != ck_q) && (transmit_clock_pin == idle_lvl)
		&& !peer_dt_oe_n;

	// idle level is learnt only after a quiet spell, so a leading edge never counts
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ck_q     <= transmit_clock_pin;
			idle_lvl <= transmit_clock_pin;
			hold_cnt <= 4'h0;
			n_trail  <= 4'h0;
		end else begin
			ck_q     <= transmit_clock_pin;
			hold_cnt <= (transmit_clock_pin != ck_q) ? 4'h0 : hold_cnt + {3'h0, hold_cnt != 4'hf};
			if (peer_dt_oe_n && hold_cnt >= 4'h6 && transmit_clock_pin == ck_q)
				idle_lvl <= transmit_clock_pin;
			n_trail  <= peer_dt_oe_n ? 4'h0 : n_trail + {3'h0, trail};
		end
	end

	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence trail_s;
		trail;
	endsequence
	sequence frame_end_s;
		$rose(peer_dt_oe_n);
	endsequence

	one_driver_a: assert property (!(!dev_ck_oe_n && !peer_ck_oe_n))
		else $error("both ends drive the link clock");
	data_steady_a: assert property (trail_s |-> $stable(receive_data_pin))
		else $error("data moved on a trailing clock edge");
	half_min_a: assert property ($changed(transmit_clock_pin) && !peer_dt_oe_n |-> hold_cnt >= 4'h3)
		else $error("link clock phase shorter than four cycles");
	char_bits_a: assert property (frame_end_s |-> n_trail == 4'h8 || n_trail == 4'h9)
		else $error("frame without eight or nine clock cycles");
	release_idle_a: assert property (frame_end_s |-> transmit_clock_pin == idle_lvl)
		else $error("data released with clock away from idle");
	data_in_phase_a: assert property ($changed(receive_data_pin) && $stable(peer_dt_oe_n)
		&& !peer_dt_oe_n |-> transmit_clock_pin != idle_lvl)
		else $error("data moved while the link clock was idle");
endmodule

`default_nettype wire

// File: bench/tb_sync_serial_receiver.sv
// self-checking bench: receiver and serial peer joined by the link interface
`timescale 1ns/1ps
`default_nettype none
`include "sync_rx_regs.svh"

module tb_sync_serial_receiver;
	// ****************
	// constants and signals
	// ****************
	localparam logic [31:0] EN = 32'h001, MS = 32'h002, SR = 32'h004, CR = 32'h008;
	localparam logic [31:0] N9 = 32'h010, HS = 32'h020, WB = 32'h040, POL = 32'h080;
	localparam logic [31:0] IE = 32'h100;
	localparam logic [8:0]  CHS [6] = '{9'h03c, 9'h0c3, 9'h055, 9'h1a5, 9'h05a, 9'h1ff};
	// fast divisor leaves room for the peer's sync and reply before each sample
	localparam logic [31:0] BAUDS [3] = '{32'h6, 32'h4, 32'h100};
	localparam logic [31:0] MODES [3] = '{HS, 32'h0, HS | WB};
	localparam logic [31:0] HALVES [3] = '{32'd7, 32'd20, 32'd257};

	logic        sys_clk = 1'b0, sys_rst = 1'b1;
	logic        hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic        master = 1'b1, pol = 1'b0, ninth = 1'b0, tx_valid = 1'b0, tx_ready;
	logic [8:0]  tx_data = 9'h000;
	int          n_mismatch = 0, samples_checked = 0, cycles = 0, k, n;

	always #5 sys_clk = ~sys_clk;

	sync_link_if link ();
	sync_serial_receiver i_sync_serial_receiver (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
		.link(link.device), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hreadyout),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .irq_o(irq));
	sync_serial_peer i_sync_serial_peer (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
		.link(link.peer), .master_i(master), .polarity_i(pol), .ninth_i(ninth),
		.tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
	sync_link_checker i_sync_link_checker (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
		.dev_ck_oe_n(link.dev_ck_oe_n), .peer_ck_oe_n(link.peer_ck_oe_n),
		.peer_dt_oe_n(link.peer_dt_oe_n), .transmit_clock_pin(link.transmit_clock_pin),
		.receive_data_pin(link.receive_data_pin));

	// ****************
	// tasks
	// ****************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons=%0d mismatches=%0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one single ahb transfer; address phase held until ready, then data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	// hand one character to the peer
	task automatic send(input logic [8:0] d);
		tx_data <= d;
		tx_valid <= 1'b1;
		do @(posedge sys_clk); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask

	// peer done, then room for push and interrupt lag
	task automatic wait_idle();
		do @(posedge sys_clk); while (tx_ready !== 1'b1);
		repeat (6) @(posedge sys_clk);
	endtask

	// length of the first clock phase away from idle
	task automatic half(input logic [31:0] exp);
		do @(posedge sys_clk); while (link.transmit_clock_pin === pol);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (link.transmit_clock_pin !== pol);
		check(n, exp);
	endtask

	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// ****************
	// test sequence
	// ****************
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		// reset values, unused bits and unmapped space
		rdchk(`OFS_CONTROL, 32'h0);
		rdchk(`OFS_STATUS, 32'h0);
		rdchk(`OFS_BAUD, 32'h0);
		ahb(1'b1, `OFS_BAUD, 32'hffff_1234);
		rdchk(`OFS_BAUD, 32'h0000_1234);
		ahb(1'b1, 8'h10, 32'hffff_ffff);
		rdchk(8'h10, 32'h0);
		ahb(1'b1, `OFS_CONTROL, 32'hffff_fe00);
		rdchk(`OFS_CONTROL, 32'h0);
		$display("test registers done");
		// slave reception, overrun in continuous mode
		ahb(1'b1, `OFS_CONTROL, EN | CR);
		for (k = 0; k < 3; k++) begin
			send(CHS[k]);
			wait_idle();
			if (k == 0) check(irq, 32'h0);
			if (k == 0) ahb(1'b1, `OFS_CONTROL, EN | CR | IE);
		end
		check(irq, 32'h1);
		check(link.dev_ck_oe_n, 32'h1);
		rdchk(`OFS_STATUS, 32'h6);
		rdchk(`OFS_DATA, 32'h3c);
		rdchk(`OFS_STATUS, 32'h6);
		rdchk(`OFS_DATA, 32'hc3);
		rdchk(`OFS_STATUS, 32'h2);
		send(9'h0f0);
		wait_idle();
		rdchk(`OFS_STATUS, 32'h2);
		ahb(1'b1, `OFS_CONTROL, EN | IE);
		rdchk(`OFS_STATUS, 32'h0);
		check(irq, 32'h0);
		$display("test slave overrun done");
		// master reception of nine-bit characters at three baud settings
		master <= 1'b0;
		pol <= 1'b1;
		ninth <= 1'b1;
		repeat (8) @(posedge sys_clk);
		for (k = 0; k < 3; k++) begin
			ahb(1'b1, `OFS_BAUD, BAUDS[k]);
			ahb(1'b1, `OFS_CONTROL, EN | MS | N9 | POL | MODES[k]);
			send(CHS[3 + k]);
			ahb(1'b1, `OFS_CONTROL, EN | MS | N9 | POL | MODES[k] | SR);
			half(HALVES[k]);
			wait_idle();
			rdchk(`OFS_CONTROL, EN | MS | N9 | POL | MODES[k]);
			check(link.transmit_clock_pin, 32'h1);
			rdchk(`OFS_STATUS, {29'h0, 1'b1, 1'b0, CHS[3 + k][8]});
			rdchk(`OFS_DATA, {24'h0, CHS[3 + k][7:0]});
		end
		$display("test master baud done");
		// single-receive overrun, cleared by a data read
		ahb(1'b1, `OFS_BAUD, 32'h6);
		for (k = 3; k < 6; k++) begin
			send(CHS[k]);
			ahb(1'b1, `OFS_CONTROL, EN | MS | N9 | POL | HS | SR);
			wait_idle();
		end
		rdchk(`OFS_STATUS, 32'h7);
		rdchk(`OFS_DATA, 32'ha5);
		rdchk(`OFS_STATUS, 32'h4);
		rdchk(`OFS_DATA, 32'h5a);
		rdchk(`OFS_STATUS, 32'h0);
		$display("test master overrun done");
		end_of_test();
	end
endmodule

`default_nettype wire
